// File: axis_ctl_pkg.sv
// Purpose: constants shared by the axis current and status block
// Assumes: 50 MHz mclk, six axes
// Notes:   parameter numbers are the host-visible register offsets
package axis_ctl_pkg;
  localparam int unsigned NUM_AXES        = 6;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned MS_CYCLES       = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned STANDBY_UNIT_MS = 10;
  localparam int unsigned STILL_CYC_LOG2  = 20;

  // register offsets
  localparam logic [7:0] OFF_BOOST_CURRENT   = 8'hc8;
  localparam logic [7:0] OFF_FREEWHEEL_DELAY = 8'hcc;
  localparam logic [7:0] OFF_LOAD_VALUE      = 8'hce;
  localparam logic [7:0] OFF_STALL_ERROR     = 8'hcf;
  localparam logic [7:0] OFF_DRIVER_FLAGS    = 8'hd0;
  localparam logic [7:0] OFF_GROUP_INDEX     = 8'hd5;
  localparam logic [7:0] OFF_STANDBY_DELAY   = 8'hd6;

  // reset values
  localparam logic [7:0]  RST_BOOST_CURRENT   = 8'h00;
  localparam logic [15:0] RST_FREEWHEEL_DELAY = 16'h0000;
  localparam logic [7:0]  RST_GROUP_INDEX     = 8'h00;
  localparam logic [15:0] RST_STANDBY_DELAY   = 16'h00c8;

  // driver flag word bit positions
  localparam int unsigned FLG_STALL     = 0;
  localparam int unsigned FLG_OT_SHUT   = 1;
  localparam int unsigned FLG_OT_WARN   = 2;
  localparam int unsigned FLG_SHORT_A   = 3;
  localparam int unsigned FLG_SHORT_B   = 4;
  localparam int unsigned FLG_OPEN_A    = 5;
  localparam int unsigned FLG_OPEN_B    = 6;
  localparam int unsigned FLG_STANDSTILL = 7;

  // motion commands
  typedef enum logic [2:0] {
    CMD_NONE                 = 3'b000,
    CMD_ROTATE_RIGHT         = 3'b001,
    CMD_ROTATE_LEFT          = 3'b010,
    CMD_MOTOR_HALT           = 3'b011,
    CMD_MOVE_TO_POSITION     = 3'b100,
    CMD_REFERENCE_SEARCH     = 3'b101
  } motion_cmd_e;

  // power state of one axis
  typedef enum logic [1:0] {
    PWR_RUN       = 2'b00,
    PWR_STANDBY   = 2'b01,
    PWR_FREEWHEEL = 2'b10
  } power_state_e;
endpackage : axis_ctl_pkg

// File: axis_current_and_status_control.sv
// Purpose: per-axis current selection, power timers, status flags, group fan-out
// Assumes: host parameter port is synchronous to mclk; one access per cycle
// Notes:   driver inputs are levels already synchronous to mclk
//          timers share one free-running ms tick, so a delay may end up to
//          one tick early; the tick is not realigned when an axis stops
`timescale 1ns/1ps

// How it works
// - boost current in ramps; zero means run
// - freewheel cut after delay; zero disables
// - ten-bit load value readable per axis
// - stall error clears on read or motion
// - flag bit 0 is stall threshold
// - flag bit 1 is overtemperature shutdown
// - flag bit 2 is overtemperature prewarning
// - flag bits 3,4 are coil shorts
// - flag bits 5,6 are open loads
// - flag bit 7 is standstill, 2^20 cycles
// - motion commands copy to same group
// - group index zero opts out
// - standby current after power-down delay
module axis_current_and_status_control
  import axis_ctl_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // host parameter port
  input  wire logic                          par_set,
  input  wire logic                          par_get,
  input  wire logic [7:0]                    par_num,
  input  wire logic [2:0]                    par_axis,
  input  wire logic [15:0]                   par_wdata,
  output logic      [15:0]                   par_rdata,
  output logic                               par_valid,
  output logic                               par_error,
  // host motion command
  input  wire logic                          cmd_valid,
  input  wire logic [2:0]                    cmd_code,
  input  wire logic [2:0]                    cmd_axis,
  output logic      [NUM_AXES-1:0]           cmd_out_valid,
  output logic      [2:0]                    cmd_out_code,
  // per-axis motion and driver state
  input  wire logic [NUM_AXES-1:0]           axis_ramping,
  input  wire logic [NUM_AXES-1:0]           axis_still,
  input  wire logic [NUM_AXES*8-1:0]         run_current,
  input  wire logic [NUM_AXES*8-1:0]         standby_current,
  input  wire logic [NUM_AXES*10-1:0]        drv_load,
  input  wire logic [NUM_AXES-1:0]           drv_stall,
  input  wire logic [NUM_AXES-1:0]           drv_ot_shut,
  input  wire logic [NUM_AXES-1:0]           drv_ot_warn,
  input  wire logic [NUM_AXES-1:0]           drv_short_a,
  input  wire logic [NUM_AXES-1:0]           drv_short_b,
  input  wire logic [NUM_AXES-1:0]           drv_open_a,
  input  wire logic [NUM_AXES-1:0]           drv_open_b,
  input  wire logic [NUM_AXES-1:0]           drv_step,
  // per-axis drive outputs
  output logic      [NUM_AXES*8-1:0]         coil_current,
  output logic      [NUM_AXES-1:0]           power_cut
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  localparam logic [3:0]  TEN_LAST = 4'(STANDBY_UNIT_MS - 1);
  // last count of the standstill window; any step restarts the window
  localparam logic [19:0] STILL_LAST = 20'((32'd1 << STILL_CYC_LOG2) - 32'd1);

  // decoding for the read and write paths and for the motion command path
  // kept as functions so that every path decodes the host fields alike
  function automatic logic known_num(input logic [7:0] n);
    known_num = (n == OFF_BOOST_CURRENT) || (n == OFF_FREEWHEEL_DELAY) ||
                (n == OFF_LOAD_VALUE) || (n == OFF_STALL_ERROR) ||
                (n == OFF_DRIVER_FLAGS) || (n == OFF_GROUP_INDEX) ||
                (n == OFF_STANDBY_DELAY);
  endfunction : known_num

  function automatic logic is_motion(input logic [2:0] c);
    is_motion = (c == CMD_ROTATE_RIGHT) || (c == CMD_ROTATE_LEFT) ||
                (c == CMD_MOTOR_HALT) || (c == CMD_MOVE_TO_POSITION) ||
                (c == CMD_REFERENCE_SEARCH);
  endfunction : is_motion

  logic        acc_ok;
  logic        cmd_ok;
  logic [15:0] ms_cnt_reg;
  logic        ms_tick;
  logic [3:0]  ten_cnt_reg;
  logic        ten_tick;

  // acceptance of a parameter access and of a motion command
  assign acc_ok = (par_axis < 3'(NUM_AXES)) && known_num(par_num);
  assign cmd_ok = cmd_valid && is_motion(cmd_code) && (cmd_axis < 3'(NUM_AXES));

  // shared millisecond divider; one divider serves all axes to save area
  // it runs free, so the first delay step after stillness may come early
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= 16'h0000;
    end else if (ms_cnt_reg == MS_LAST) begin
      ms_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end
  assign ms_tick = (ms_cnt_reg == MS_LAST);

  // ten-millisecond tick for the standby delay
  // it counts ms ticks, so both power timers stay in step with each other
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ten_cnt_reg <= 4'h0;
    end else if (ms_tick) begin
      ten_cnt_reg <= (ten_cnt_reg == TEN_LAST) ? 4'h0 : ten_cnt_reg + 4'h1;
    end
  end
  assign ten_tick = ms_tick && (ten_cnt_reg == TEN_LAST);

  // per-axis state
  // written inside the axis slices, read by the host mux and the fan-out
  logic [7:0]          boost_current_reg   [NUM_AXES];
  logic [15:0]         freewheel_delay_reg [NUM_AXES];
  logic [7:0]          group_index_reg     [NUM_AXES];
  logic [15:0]         standby_delay_reg   [NUM_AXES];
  logic [NUM_AXES-1:0] stall_error_reg;
  logic [7:0]          driver_flags        [NUM_AXES];
  logic [NUM_AXES-1:0] cmd_hit;

  // group fan-out: the addressed axis plus every axis sharing its nonzero group
  // the addressed axis is always hit, even when its own group is zero
  // a zero group never matches, so unrelated axes stay quiet
  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      cmd_hit[i] = 1'b0;
      if (cmd_ok) begin
        cmd_hit[i] = (3'(i) == cmd_axis) ||
                     ((group_index_reg[cmd_axis] != 8'h00) &&
                      (group_index_reg[i] == group_index_reg[cmd_axis]));
      end
    end
  end

  // registered command outputs to the motion engine
  // refused commands forward no code, so the engine only sees real hits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_out_valid <= '0;
      cmd_out_code  <= CMD_NONE;
    end else begin
      cmd_out_valid <= cmd_hit;
      cmd_out_code  <= cmd_ok ? cmd_code : CMD_NONE;
    end
  end

  // one slice per axis; slices share only the ticks and the fan-out vector
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      logic [19:0]  still_cnt_reg;
      logic         standstill_reg;
      logic [15:0]  fw_cnt_reg;
      logic [15:0]  sb_cnt_reg;
      power_state_e pwr_reg;
      logic         wr_hit;
      logic [7:0]   run_i;
      logic [7:0]   sby_i;
      logic         stall_rd;
      logic         restart;
      logic         fw_due;

      assign wr_hit = par_set && acc_ok && (par_axis == 3'(g));
      assign run_i  = run_current[g*8 +: 8];
      assign sby_i  = standby_current[g*8 +: 8];

      // a stall read clears the flag; leaving stillness restarts the timers
      assign stall_rd = par_get && (par_num == OFF_STALL_ERROR) && (par_axis == 3'(g));
      assign restart  = !axis_still[g] || cmd_hit[g];

      // writable parameters; read-only numbers fall to the default branch
      // and are dropped without an error, like any write to a status value
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          boost_current_reg[g]   <= RST_BOOST_CURRENT;
          freewheel_delay_reg[g] <= RST_FREEWHEEL_DELAY;
          group_index_reg[g]     <= RST_GROUP_INDEX;
          standby_delay_reg[g]   <= RST_STANDBY_DELAY;
        end else if (wr_hit) begin
          case (par_num)
            OFF_BOOST_CURRENT:   boost_current_reg[g]   <= par_wdata[7:0];
            OFF_FREEWHEEL_DELAY: freewheel_delay_reg[g] <= par_wdata;
            OFF_GROUP_INDEX:     group_index_reg[g]     <= par_wdata[7:0];
            OFF_STANDBY_DELAY: begin
              // zero is outside the legal range, so clamp to one unit
              standby_delay_reg[g] <= (par_wdata == 16'h0000) ? 16'h0001 : par_wdata;
            end
            default: ;
          endcase
        end
      end

      // standstill detector on the driver step input
      // the counter parks at its last value, so the flag never wraps back
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          still_cnt_reg  <= 20'h00000;
          standstill_reg <= 1'b0;
        end else if (drv_step[g]) begin
          still_cnt_reg  <= 20'h00000;
          standstill_reg <= 1'b0;
        end else if (still_cnt_reg == STILL_LAST) begin
          standstill_reg <= 1'b1;
        end else begin
          still_cnt_reg <= still_cnt_reg + 20'h00001;
        end
      end

      // driver flag word
      // levels pass straight through; the host sees them on the next edge
      always_comb begin
        driver_flags[g]                 = 8'h00;
        driver_flags[g][FLG_STALL]      = drv_stall[g];
        driver_flags[g][FLG_OT_SHUT]    = drv_ot_shut[g];
        driver_flags[g][FLG_OT_WARN]    = drv_ot_warn[g];
        driver_flags[g][FLG_SHORT_A]    = drv_short_a[g];
        driver_flags[g][FLG_SHORT_B]    = drv_short_b[g];
        driver_flags[g][FLG_OPEN_A]     = drv_open_a[g];
        driver_flags[g][FLG_OPEN_B]     = drv_open_b[g];
        driver_flags[g][FLG_STANDSTILL] = standstill_reg;
      end

      // sticky stall error; a new stall in the clearing cycle wins
      // a read returns the old value at the same edge that clears it
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          stall_error_reg[g] <= 1'b0;
        end else if (drv_stall[g]) begin
          stall_error_reg[g] <= 1'b1;
        end else if (cmd_hit[g] || stall_rd) begin
          stall_error_reg[g] <= 1'b0;
        end
      end

      // freewheel is due once the programmed ms have passed; zero never cuts
      assign fw_due = (freewheel_delay_reg[g] != 16'h0000) &&
                      (fw_cnt_reg >= freewheel_delay_reg[g]);

      // freewheel timer in ms; saturates so a long still spell cannot wrap
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          fw_cnt_reg <= 16'h0000;
        end else if (restart) begin
          fw_cnt_reg <= 16'h0000;
        end else if (ms_tick && fw_cnt_reg != 16'hffff) begin
          fw_cnt_reg <= fw_cnt_reg + 16'h0001;
        end
      end

      // standby timer in 10 ms units; saturates like the freewheel timer
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          sb_cnt_reg <= 16'h0000;
        end else if (restart) begin
          sb_cnt_reg <= 16'h0000;
        end else if (ten_tick && sb_cnt_reg != 16'hffff) begin
          sb_cnt_reg <= sb_cnt_reg + 16'h0001;
        end
      end

      // power state; freewheel beats standby and only motion leaves it
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pwr_reg <= PWR_RUN;
        end else if (restart) begin
          pwr_reg <= PWR_RUN;
        end else begin
          case (pwr_reg)
            PWR_RUN: begin
              if (fw_due) begin
                pwr_reg <= PWR_FREEWHEEL;
              end else if (sb_cnt_reg >= standby_delay_reg[g]) begin
                pwr_reg <= PWR_STANDBY;
              end
            end
            PWR_STANDBY: begin
              if (fw_due) begin
                pwr_reg <= PWR_FREEWHEEL;
              end
            end
            PWR_FREEWHEEL: pwr_reg <= PWR_FREEWHEEL;
            default:       pwr_reg <= PWR_RUN;
          endcase
        end
      end

      // current selection and power cut, registered
      // standby and freewheel override boost, so an axis in either state never boosts
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          coil_current[g*8 +: 8] <= 8'h00;
          power_cut[g]           <= 1'b0;
        end else begin
          power_cut[g] <= (pwr_reg == PWR_FREEWHEEL);
          if (pwr_reg == PWR_FREEWHEEL) begin
            coil_current[g*8 +: 8] <= 8'h00;
          end else if (pwr_reg == PWR_STANDBY) begin
            coil_current[g*8 +: 8] <= sby_i;
          end else if (axis_ramping[g] && boost_current_reg[g] != 8'h00) begin
            coil_current[g*8 +: 8] <= boost_current_reg[g];
          end else begin
            coil_current[g*8 +: 8] <= run_i;
          end
        end
      end
    end
  endgenerate

  // read path; answer one cycle after the request
  // a refused access answers with the error flag and zero data
  // unused upper bits of narrow parameters read as zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      par_rdata <= 16'h0000;
      par_valid <= 1'b0;
      par_error <= 1'b0;
    end else begin
      par_valid <= par_set || par_get;
      par_error <= (par_set || par_get) && !acc_ok;
      par_rdata <= 16'h0000;
      if (par_get && acc_ok) begin
        case (par_num)
          OFF_BOOST_CURRENT:   par_rdata <= {8'h00, boost_current_reg[par_axis]};
          OFF_FREEWHEEL_DELAY: par_rdata <= freewheel_delay_reg[par_axis];
          OFF_LOAD_VALUE:      par_rdata <= {6'h00, drv_load[par_axis*10 +: 10]};
          OFF_STALL_ERROR:     par_rdata <= {15'h0000, stall_error_reg[par_axis]};
          OFF_DRIVER_FLAGS:    par_rdata <= {8'h00, driver_flags[par_axis]};
          OFF_GROUP_INDEX:     par_rdata <= {8'h00, group_index_reg[par_axis]};
          OFF_STANDBY_DELAY:   par_rdata <= standby_delay_reg[par_axis];
          default:             par_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : axis_current_and_status_control

// File: axis_ctl_monitor.sv
// Purpose: port-level checks for the axis current and status block
// Assumes: single mclk domain, async active-low reset
// Notes:   stable-input guards allow one cycle of flag capture lag
`timescale 1ns/1ps
module axis_ctl_monitor
  import axis_ctl_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire logic                   par_set,
  input wire logic                   par_get,
  input wire logic [7:0]             par_num,
  input wire logic [2:0]             par_axis,
  input wire logic [15:0]            par_rdata,
  input wire logic                   par_valid,
  input wire logic                   par_error,
  input wire logic                   cmd_valid,
  input wire logic [2:0]             cmd_code,
  input wire logic [2:0]             cmd_axis,
  input wire logic [NUM_AXES-1:0]    cmd_out_valid,
  input wire logic [2:0]             cmd_out_code,
  input wire logic [NUM_AXES*10-1:0] drv_load,
  input wire logic [NUM_AXES-1:0]    drv_ot_shut,
  input wire logic [NUM_AXES*8-1:0]  coil_current,
  input wire logic [NUM_AXES-1:0]    power_cut
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // parameter port answers and nothing else
  a_par_answer: assert property ((par_set || par_get) |=> par_valid)
    else $error("no answer one cycle after access");
  a_par_cause: assert property (par_valid |-> $past(par_set || par_get))
    else $error("answer without access");
  a_bad_axis: assert property ((par_get && par_axis > 3'h5) |=> par_error)
    else $error("bad axis not refused");
  a_load_read: assert property ((par_get && par_num == 8'hce && par_axis == 3'h0
    && drv_load[9:0] == $past(drv_load[9:0]))
    |=> par_rdata == {6'h00, $past(drv_load[9:0])}) else $error("load readback wrong");
  a_ot_flag: assert property ((par_get && par_num == 8'hd0 && par_axis == 3'h0
    && drv_ot_shut[0] == $past(drv_ot_shut[0]))
    |=> par_rdata[1] == $past(drv_ot_shut[0])) else $error("shutdown flag wrong");
  // command fan-out always hits the addressed axis itself
  a_group_hit: assert property ((cmd_valid && cmd_code inside {[3'h1:3'h5]}
    && cmd_axis < 3'h6) |=> cmd_out_valid[$past(cmd_axis)])
    else $error("addressed axis missed");
  a_cmd_code: assert property ((|cmd_out_valid) |-> cmd_out_code == $past(cmd_code))
    else $error("forwarded code differs");
  a_cmd_quiet: assert property ((!cmd_valid || cmd_code == 3'h0) |=> cmd_out_valid == 6'h00)
    else $error("spurious command output");
  a_cut_zero: assert property (power_cut[3] |-> coil_current[31:24] == 8'h00)
    else $error("current while power cut");

  c_refused: cover property (par_error);
  c_group: cover property (cmd_out_valid == 6'h11);
  c_cut: cover property ($rose(power_cut[3]));
endmodule : axis_ctl_monitor

// File: drv_stage_model.sv
// Purpose: behavioural driver stage feeding load, fault and step levels
// Assumes: faults land on one chosen axis at a time
// Notes:   steady steps keep standstill clear; long idle is not modelled
`timescale 1ns/1ps
module drv_stage_model
  import axis_ctl_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic [6:0]             fault,
  input  wire logic [2:0]             fault_axis,
  output logic      [NUM_AXES*10-1:0] drv_load,
  output logic      [NUM_AXES-1:0]    drv_stall,
  output logic      [NUM_AXES-1:0]    drv_ot_shut,
  output logic      [NUM_AXES-1:0]    drv_ot_warn,
  output logic      [NUM_AXES-1:0]    drv_short_a,
  output logic      [NUM_AXES-1:0]    drv_short_b,
  output logic      [NUM_AXES-1:0]    drv_open_a,
  output logic      [NUM_AXES-1:0]    drv_open_b,
  output logic      [NUM_AXES-1:0]    drv_step
);
  logic [3:0] step_cnt_reg = 4'h0;

  // one axis only, so a swapped axis index shows up as a wrong read
  assign drv_stall   = {5'h00, fault[0]} << fault_axis;
  assign drv_ot_shut = {5'h00, fault[1]} << fault_axis;
  assign drv_ot_warn = {5'h00, fault[2]} << fault_axis;
  assign drv_short_a = {5'h00, fault[3]} << fault_axis;
  assign drv_short_b = {5'h00, fault[4]} << fault_axis;
  assign drv_open_a  = {5'h00, fault[5]} << fault_axis;
  assign drv_open_b  = {5'h00, fault[6]} << fault_axis;

  // distinct full-scale loads per axis
  for (genvar i = 0; i < NUM_AXES; i++) begin : g_load
    assign drv_load[10*i +: 10] = 10'h3ff - 10'(i);
  end

  // a step pulse on every axis each 16 cycles
  always_ff @(posedge mclk) begin
    step_cnt_reg <= step_cnt_reg + 4'h1;
  end
  assign drv_step = {NUM_AXES{step_cnt_reg == 4'h0}};
endmodule : drv_stage_model

// File: axis_current_and_status_control_tb.sv
// Purpose: directed test of the axis current and status block
// Assumes: 50 MHz mclk, fixed 50000-cycle ms tick
// Notes:   standby and standstill spans exceed the run budget
`timescale 1ns/1ps
module axis_current_and_status_control_tb;
  import axis_ctl_pkg::*;
  logic mclk, arst_n = 1'b0, par_set = 1'b0, par_get = 1'b0, par_valid, par_error;
  logic cmd_valid = 1'b0;
  logic [7:0]  par_num = 8'h00;
  logic [2:0]  par_axis = 3'h0, cmd_code = 3'h0, cmd_axis = 3'h0, cmd_out_code;
  logic [2:0]  fault_axis = 3'h0;
  logic [6:0]  fault = 7'h00;
  logic [15:0] par_wdata = 16'h0000, par_rdata;
  logic [5:0]  cmd_out_valid, power_cut, axis_ramping = 6'h00, axis_still = 6'h00;
  logic [5:0]  drv_stall, drv_ot_shut, drv_ot_warn, drv_short_a, drv_short_b;
  logic [5:0]  drv_open_a, drv_open_b, drv_step;
  logic [47:0] run_current = {6{8'h20}}, standby_current = {6{8'h08}}, coil_current;
  logic [59:0] drv_load;
  int          err_total = 0, total_checks = 0, n;

  axis_current_and_status_control u_axis_current_and_status_control (.mclk, .arst_n,
    .par_set, .par_get, .par_num, .par_axis, .par_wdata, .par_rdata, .par_valid,
    .par_error, .cmd_valid, .cmd_code, .cmd_axis, .cmd_out_valid, .cmd_out_code,
    .axis_ramping, .axis_still, .run_current, .standby_current, .drv_load, .drv_stall,
    .drv_ot_shut, .drv_ot_warn, .drv_short_a, .drv_short_b, .drv_open_a, .drv_open_b,
    .drv_step, .coil_current, .power_cut);
  drv_stage_model u_drv_stage_model (.mclk, .fault, .fault_axis, .drv_load, .drv_stall,
    .drv_ot_shut, .drv_ot_warn, .drv_short_a, .drv_short_b, .drv_open_a, .drv_open_b,
    .drv_step);

  // clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one parameter access, left settled just after its answer edge
  task automatic acc(input logic wr, input logic [7:0] num, input logic [2:0] ax,
                     input logic [15:0] wd);
    @(posedge mclk);
    par_set   <= wr;
    par_get   <= !wr;
    par_num   <= num;
    par_axis  <= ax;
    par_wdata <= wd;
    @(posedge mclk);
    par_set <= 1'b0;
    par_get <= 1'b0;
    #1;
  endtask : acc

  task automatic getp(input logic [7:0] num, input logic [2:0] ax, input logic [15:0] exp);
    acc(1'b0, num, ax, 16'h0000);
    chk(par_rdata, exp);
  endtask : getp

  task automatic mcmd(input logic [2:0] code, input logic [2:0] ax, input logic [5:0] exp);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_axis  <= ax;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    chk({10'h000, cmd_out_valid}, {10'h000, exp});
    if (exp !== 6'h00) chk({13'h0000, cmd_out_code}, {13'h0000, code});
  endtask : mcmd

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // watchdog sized above one ms of freewheel wait plus the short tests
  initial begin
    repeat (80000) @(posedge mclk);
    err_total++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    getp(8'hc8, 3'h0, 16'h0000);
    getp(8'hcc, 3'h0, 16'h0000);
    getp(8'hd5, 3'h5, 16'h0000);
    getp(8'hd6, 3'h0, 16'h00c8);
    getp(8'hce, 3'h0, 16'h03ff);
    acc(1'b1, 8'hce, 3'h0, 16'h0001);
    getp(8'hce, 3'h0, 16'h03ff);
    getp(8'hce, 3'h5, 16'h03fa);
    acc(1'b1, 8'hd6, 3'h0, 16'h0000);
    getp(8'hd6, 3'h0, 16'h0001);
    acc(1'b0, 8'hc8, 3'h6, 16'h0000);
    chk({15'h0000, par_error}, 16'h0001);
    $display("test registers done");
    @(posedge mclk) fault_axis <= 3'h2;
    for (int b = 0; b < 7; b++) begin
      @(posedge mclk) fault <= 7'(1 << b);
      settle();
      getp(8'hd0, 3'h2, 16'(1 << b));
      getp(8'hd0, 3'h0, 16'h0000);
    end
    @(posedge mclk) fault <= 7'h00;
    $display("test flags done");
    getp(8'hcf, 3'h2, 16'h0001);
    getp(8'hcf, 3'h2, 16'h0000);
    @(posedge mclk) fault <= 7'h01;
    settle();
    @(posedge mclk) fault <= 7'h00;
    mcmd(3'h3, 3'h2, 6'h04);
    getp(8'hcf, 3'h2, 16'h0000);
    $display("test stall done");
    acc(1'b1, 8'hd5, 3'h0, 16'h0003);
    acc(1'b1, 8'hd5, 3'h4, 16'h0003);
    for (int c = 1; c < 6; c++) mcmd(3'(c), 3'h0, 6'h11);
    mcmd(3'h2, 3'h4, 6'h11);
    mcmd(3'h1, 3'h1, 6'h02);
    mcmd(3'h0, 3'h0, 6'h00);
    $display("test group done");
    @(posedge mclk) axis_ramping <= 6'h02;
    acc(1'b1, 8'hc8, 3'h1, 16'h0040);
    settle();
    chk({8'h00, coil_current[15:8]}, 16'h0040);
    chk({8'h00, coil_current[7:0]}, 16'h0020);
    acc(1'b1, 8'hc8, 3'h1, 16'h0000);
    settle();
    chk({8'h00, coil_current[15:8]}, 16'h0020);
    $display("test boost done");
    acc(1'b1, 8'hcc, 3'h3, 16'h0001);
    @(posedge mclk) axis_still <= 6'h28;
    // looked at off the edge; the cut must follow within one ms tick
    for (n = 0; n < 60000 && power_cut[3] !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk({15'h0000, n <= MS_CYCLES + 10}, 16'h0001);
    chk({10'h000, power_cut}, 16'h0008);
    @(posedge mclk) axis_still <= 6'h20;
    settle();
    chk({10'h000, power_cut}, 16'h0000);
    $display("test freewheel done");
    conclude();
  end
endmodule : axis_current_and_status_control_tb

bind axis_current_and_status_control axis_ctl_monitor u_axis_ctl_monitor (.mclk, .arst_n,
  .par_set, .par_get, .par_num, .par_axis, .par_rdata, .par_valid, .par_error, .cmd_valid,
  .cmd_code, .cmd_axis, .cmd_out_valid, .cmd_out_code, .drv_load, .drv_ot_shut,
  .coil_current, .power_cut);
